/* File: fault_stage.sv */
`timescale 1ns/1ps
module fault_stage (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic fault_cmd,
  input  wire logic cmp_cmd,
  output logic      fault_input_pin,
  output logic      comparator_out
);
  // pin has a pull-up and the comparator idles high, so both read high in reset
  always_ff @(posedge ref_clk or negedge rst_b)
    if (!rst_b)
    begin
      fault_input_pin <= 1'b1;
      comparator_out  <= 1'b1;
    end
    else
    begin
      fault_input_pin <= fault_cmd;
      comparator_out  <= cmp_cmd;
    end
endmodule : fault_stage

/* File: pwm_fault_ctrl.sv */
// Functional notes
// - channel A shadow mirrors primary mode field
// - channel B shadow mirrors primary mode field
// - nonzero D mode hands pin to waveform
// - inverted D pin only PWM with 01
// - non-PWM: toggle, clear, set on match
// - fast PWM: 01 and 10 clear on match, set zero
// - dual slope: 01 and 10 up clears, down sets
// - force applies action, new mode used
// - force bit always reads zero
// - D PWM enable selects PWM behaviour
// - fault interrupt only when enabled
// - fault mode enable activates protection
// - filter needs four equal samples
// - edge select: zero falling, one rising
// - comparator source through same front end
// - fault detected even as output pin
// - flag clears on vector or write-one
// - normal and dual-slope mode update points
// - wave codes select PFC and six-phase
// - six override bits gate pins in six-phase mode
// - cleared override drives port data in six-phase mode
`timescale 1ns/1ps
`include "timer_params.svh"
module pwm_fault_ctrl
  import timer_pkg::*;
#(
  parameter int FILT_LEN = `TMR_FILT_SAMPLES
)(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire apb_req_t      apb_req,
  output apb_rsp_t           apb_rsp,
  input  wire cnt_evt_t      cnt_evt,
  input  wire logic          chan_a_wave,
  input  wire logic          chan_b_wave,
  input  wire logic          chan_d_dir,
  input  wire logic          fault_input_pin,
  input  wire logic          comparator_out,
  input  wire logic          global_irq_en,
  input  wire logic          fault_irq_ack,
  output logic               chan_d_waveform,
  output logic               chan_d_conn,
  output logic               chan_d_inv_conn,
  output logic               chan_d_oe_b,
  output logic [5:0]         pin_out,
  output logic               six_phase_mode,
  output logic               upd_immediate,
  output logic               upd_at_bottom,
  output logic               fault_mode_active,
  output logic               fault_trip,
  output logic               fault_irq
);

  // elaboration check on the filter length
  if (FILT_LEN < 2 || FILT_LEN > 16)
  begin : g_bad_len
    $error("FILT_LEN must be 2 to 16");
  end

  // control registers
  logic [1:0]          com_a_r;
  logic [1:0]          com_b_r;
  logic [1:0]          com_d_r;
  logic                pwm_a_r;
  logic                pwm_b_r;
  logic                pwm_d_r;
  logic                fpie_r;
  logic                fpen_r;
  logic                fpnc_r;
  logic                fpes_r;
  logic                fpac_r;
  logic                fault_flag_r;
  logic                fault_flag_nxt;
  logic [1:0]          wave_r;
  logic [5:0]          oe_r;
  logic [5:0]          port_r;
  logic                clr_pend_r;
  // bus signals
  logic                pready_r;
  logic                pslverr_r;
  logic [31:0]         prdata_r;
  logic                acc;
  logic                do_wr;
  logic [5:0]          idx;
  logic                hit_a;
  logic                hit_c;
  logic                hit_d;
  logic                hit_e;
  logic                hit_p;
  logic                mapped;
  logic [7:0]          wdat;
  logic [7:0]          rd_byte;
  // fault front end
  logic                pin_s1_r;
  logic                pin_s2_r;
  logic                cmp_s1_r;
  logic                cmp_s2_r;
  logic                src;
  logic [FILT_LEN-1:0] hist_r;
  logic                filt_r;
  logic                fsel;
  logic                prev_r;
  logic                fault_evt;
  // waveform
  logic                wave_d_r;
  logic                wave_d_nxt;
  logic                force_now;
  logic                pwm_any;
  logic [5:0]          wsrc;
  // output flops
  logic                conn_r;
  logic                inv_conn_r;
  logic                oe_b_r;
  logic [5:0]          pin_out_r;
  logic                six_r;
  logic                upd_imm_r;
  logic                upd_bot_r;
  logic                fmode_r;
  logic                trip_r;
  logic                irq_r;

  // apb decode, word index from byte address
  assign acc    = apb_req.psel & apb_req.penable;
  assign idx    = apb_req.paddr[`TMR_ADDR_W-1:2];
  assign hit_a  = (idx == `TMR_IDX_CTRL_A) && (apb_req.paddr[1:0] == 2'h0);
  assign hit_c  = (idx == `TMR_IDX_CTRL_C) && (apb_req.paddr[1:0] == 2'h0);
  assign hit_d  = (idx == `TMR_IDX_CTRL_D) && (apb_req.paddr[1:0] == 2'h0);
  assign hit_e  = (idx == `TMR_IDX_CTRL_E) && (apb_req.paddr[1:0] == 2'h0);
  assign hit_p  = (idx == `TMR_IDX_PORT) && (apb_req.paddr[1:0] == 2'h0);
  assign mapped = hit_a | hit_c | hit_d | hit_e | hit_p;
  assign do_wr  = ce & acc & pready_r & apb_req.pwrite & mapped;
  assign wdat   = apb_req.pwdata[7:0];

  // read mux, reserved bits as zero
  always_comb
  begin
    rd_byte = `TMR_RST_BYTE;
    if (hit_c)
    begin
      rd_byte[`TMR_C_COMA] = com_a_r;
      rd_byte[`TMR_C_COMB] = com_b_r;
      rd_byte[`TMR_C_COMD] = com_d_r;
      rd_byte[`TMR_C_FORCE] = 1'b0;
      rd_byte[`TMR_C_PWMD] = pwm_d_r;
    end
    else if (hit_a)
    begin
      rd_byte[`TMR_A_COMA] = com_a_r;
      rd_byte[`TMR_A_COMB] = com_b_r;
      rd_byte[`TMR_A_PWMA] = pwm_a_r;
      rd_byte[`TMR_A_PWMB] = pwm_b_r;
    end
    else if (hit_d)
    begin
      rd_byte = {fpie_r, fpen_r, fpnc_r, fpes_r, fpac_r, fault_flag_r, wave_r};
    end
    else if (hit_e)
    begin
      rd_byte[`TMR_E_OE] = oe_r;
    end
    else if (hit_p)
    begin
      rd_byte[`TMR_E_OE] = port_r;
    end
  end

  // apb answer: one wait state, pready high in second access cycle
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= `TMR_RST_WORD;
    end
    else if (ce)
    begin
      pready_r  <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~mapped;
      if (acc && !pready_r && !apb_req.pwrite)
        prdata_r <= {24'h00_0000, rd_byte};
    end
  end
  assign apb_rsp = '{pready: pready_r, pslverr: pslverr_r, prdata: prdata_r};

  // shared channel A and B mode fields, one store for both views
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      com_a_r <= `TMR_COM_PORT;
      com_b_r <= `TMR_COM_PORT;
      pwm_a_r <= 1'b0;
      pwm_b_r <= 1'b0;
    end
    else if (do_wr)
    begin
      if (hit_c)
      begin
        com_a_r <= wdat[`TMR_C_COMA];
        com_b_r <= wdat[`TMR_C_COMB];
      end
      else if (hit_a)
      begin
        com_a_r <= wdat[`TMR_A_COMA];
        com_b_r <= wdat[`TMR_A_COMB];
        pwm_a_r <= wdat[`TMR_A_PWMA];
        pwm_b_r <= wdat[`TMR_A_PWMB];
      end
    end
  end

  // channel D control
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      com_d_r <= `TMR_COM_PORT;
      pwm_d_r <= 1'b0;
    end
    else if (do_wr && hit_c)
    begin
      com_d_r <= wdat[`TMR_C_COMD];
      pwm_d_r <= wdat[`TMR_C_PWMD];
    end
  end

  // fault control, wave mode, override and port data
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fpie_r <= 1'b0;
      fpen_r <= 1'b0;
      fpnc_r <= 1'b0;
      fpes_r <= 1'b0;
      fpac_r <= 1'b0;
      wave_r <= WAVE_FAST;
      oe_r   <= 6'h00;
      port_r <= 6'h00;
    end
    else if (do_wr)
    begin
      if (hit_d)
      begin
        fpie_r <= wdat[`TMR_D_FPIE];
        fpen_r <= wdat[`TMR_D_FPEN];
        fpnc_r <= wdat[`TMR_D_FPNC];
        fpes_r <= wdat[`TMR_D_FPES];
        fpac_r <= wdat[`TMR_D_FPAC];
        wave_r <= wdat[`TMR_D_WAVE];
      end
      if (hit_e)
        oe_r <= wdat[`TMR_E_OE];
      if (hit_p)
        port_r <= wdat[`TMR_E_OE];
    end
  end

  // two-flop synchronisers for pin and comparator
  // start at the idle high level so reset release shows no false edge
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      cmp_s1_r <= 1'b1;
      cmp_s2_r <= 1'b1;
    end
    else if (ce)
    begin
      pin_s1_r <= fault_input_pin;
      pin_s2_r <= pin_s1_r;
      cmp_s1_r <= comparator_out;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  assign src = fpac_r ? cmp_s2_r : pin_s2_r;

  // noise filter: output follows only a full run of equal samples
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hist_r <= '1;
      filt_r <= 1'b1;
    end
    else if (ce)
    begin
      hist_r <= {hist_r[FILT_LEN-2:0], src};
      if (&hist_r)
        filt_r <= 1'b1;
      else if (~|hist_r)
        filt_r <= 1'b0;
    end
  end

  assign fsel = fpnc_r ? filt_r : src;

  assign fault_evt = fpes_r ? (fsel & ~prev_r) : (~fsel & prev_r);

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      prev_r <= 1'b1;
    else if (ce)
      prev_r <= fsel;
  end

  // flag: set wins over clears
  always_comb
  begin
    fault_flag_nxt = fault_flag_r;
    if (clr_pend_r || fault_irq_ack)
      fault_flag_nxt = 1'b0;
    if (fault_evt)
      fault_flag_nxt = 1'b1;
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fault_flag_r <= 1'b0;
      clr_pend_r   <= 1'b0;
    end
    else if (ce)
    begin
      fault_flag_r <= fault_flag_nxt;
      clr_pend_r   <= do_wr & hit_d & wdat[`TMR_D_FLAG];
    end
  end

  // interrupt, protection mode and trip pulse
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irq_r   <= 1'b0;
      fmode_r <= 1'b0;
      trip_r  <= 1'b0;
    end
    else if (ce)
    begin
      irq_r   <= fault_flag_r & fpie_r & global_irq_en;
      fmode_r <= fpen_r;
      trip_r  <= fpen_r & fault_evt;
    end
  end

  // force uses mode and enable written with it
  assign force_now = do_wr & hit_c & wdat[`TMR_C_FORCE] & ~wdat[`TMR_C_PWMD];

  // channel D waveform next value
  always_comb
  begin
    wave_d_nxt = wave_d_r;
    if (force_now)
    begin
      unique case (wdat[`TMR_C_COMD])
        `TMR_COM_PORT:   wave_d_nxt = wave_d_r;
        `TMR_COM_TOGGLE: wave_d_nxt = ~wave_d_r;
        `TMR_COM_CLEAR:  wave_d_nxt = 1'b0;
        `TMR_COM_SET:    wave_d_nxt = 1'b1;
      endcase
    end
    else if (!pwm_d_r)
    begin
      if (cnt_evt.chan_d_match)
      begin
        unique case (com_d_r)
          `TMR_COM_PORT:   wave_d_nxt = wave_d_r;
          `TMR_COM_TOGGLE: wave_d_nxt = ~wave_d_r;
          `TMR_COM_CLEAR:  wave_d_nxt = 1'b0;
          `TMR_COM_SET:    wave_d_nxt = 1'b1;
        endcase
      end
    end
    else if (com_d_r != `TMR_COM_PORT)
    begin
      if (wave_r[0] == 1'b0)
      begin
        // fast pwm, match wins over zero
        if (cnt_evt.chan_d_match)
          wave_d_nxt = (com_d_r == `TMR_COM_SET);
        else if (cnt_evt.counter_zero)
          wave_d_nxt = (com_d_r != `TMR_COM_SET);
      end
      else if (cnt_evt.chan_d_match)
      begin
        wave_d_nxt = cnt_evt.count_down ^ (com_d_r == `TMR_COM_SET);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      wave_d_r <= 1'b0;
    else if (ce)
      wave_d_r <= wave_d_nxt;
  end
  assign chan_d_waveform = wave_d_r;

  // channel D pin connections
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      conn_r     <= 1'b0;
      inv_conn_r <= 1'b0;
      oe_b_r     <= 1'b1;
    end
    else if (ce)
    begin
      // nonzero mode takes pin, direction enables driver
      conn_r     <= (com_d_r != `TMR_COM_PORT);
      oe_b_r     <= ~((com_d_r != `TMR_COM_PORT) & chan_d_dir);
      // inverted pin only pwm and toggle code
      inv_conn_r <= pwm_d_r & (com_d_r == `TMR_COM_TOGGLE);
    end
  end

  // mode decode and update points
  assign pwm_any = pwm_a_r | pwm_b_r;
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      six_r     <= 1'b0;
      upd_imm_r <= 1'b1;
      upd_bot_r <= 1'b0;
    end
    else if (ce)
    begin
      upd_imm_r <= ~pwm_any;
      // codes 01 and 11 at bottom, 1x six-phase
      upd_bot_r <= pwm_any & wave_r[0];
      six_r     <= pwm_any & wave_r[1];
    end
  end

  // waveform source per pin pair, odd pin carries complement
  assign wsrc = {~wave_d_r, wave_d_r, ~chan_b_wave, chan_b_wave,
                 ~chan_a_wave, chan_a_wave};

  for (genvar i = 0; i < 6; i++)
  begin : g_pin
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
      if (!rst_b)
        pin_out_r[i] <= 1'b0;
      else if (ce)
      begin
        pin_out_r[i] <= (six_r && !oe_r[i]) ? port_r[i] : wsrc[i];
      end
    end
  end

  assign chan_d_conn       = conn_r;
  assign chan_d_inv_conn   = inv_conn_r;
  assign chan_d_oe_b       = oe_b_r;
  assign pin_out           = pin_out_r;
  assign six_phase_mode    = six_r;
  assign upd_immediate     = upd_imm_r;
  assign upd_at_bottom     = upd_bot_r;
  assign fault_mode_active = fmode_r;
  assign fault_trip        = trip_r;
  assign fault_irq         = irq_r;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  sequence s_wr_clr;
    do_wr && hit_d && wdat[`TMR_D_FLAG];
  endsequence
  sequence s_quiet;
    ce && !fault_evt && !fault_irq_ack;
  endsequence

  a_shadow_a_sync: assert property (do_wr && hit_c |=> com_a_r == $past(wdat[`TMR_C_COMA]))
    else $error("channel A mode not mirrored");
  a_shadow_b_sync: assert property (do_wr && hit_a |=> com_b_r == $past(wdat[`TMR_A_COMB]))
    else $error("channel B mode not mirrored");
  a_inv_pin_gate: assert property (ce ##1 inv_conn_r |-> $past(pwm_d_r) && conn_r)
    else $error("inverted pin connected outside pwm");
  a_force_read: assert property (pready_r && hit_c && !apb_req.pwrite
                                 |-> !prdata_r[`TMR_C_FORCE])
    else $error("force bit read as one");
  a_flag_set: assert property (ce && fault_evt |=> fault_flag_r)
    else $error("fault event lost");
  a_flag_clear: assert property (s_wr_clr ##1 s_quiet |=> !fault_flag_r)
    else $error("flag not cleared by write one");
  a_irq_enable: assert property (ce && !fpie_r |=> !irq_r)
    else $error("fault irq without enable");
  a_filter_hold: assert property (ce && fpnc_r && (|hist_r) && !(&hist_r)
                                  |=> filt_r == $past(filt_r))
    else $error("filter moved without equal run");
  a_fast_pwm_set: assert property (ce && pwm_d_r && !wave_r[0] && !force_now
                                   && (com_d_r == `TMR_COM_TOGGLE || com_d_r == `TMR_COM_CLEAR)
                                   && cnt_evt.counter_zero
                                   && !cnt_evt.chan_d_match |=> wave_d_r)
    else $error("fast pwm not set at zero");
  a_override_port: assert property (ce && six_r && !oe_r[0] |=> pin_out_r[0] == $past(port_r[0]))
    else $error("override off does not show port");

endmodule : pwm_fault_ctrl

/* File: testbench.sv */
`timescale 1ns/1ps
`include "timer_params.svh"
module testbench;
  import timer_pkg::*;
  localparam logic [7:0] A_C = {`TMR_IDX_CTRL_C, 2'b00};
  localparam logic [7:0] A_D = {`TMR_IDX_CTRL_D, 2'b00};
  localparam logic [7:0] A_E = {`TMR_IDX_CTRL_E, 2'b00};
  localparam logic [7:0] A_P = {`TMR_IDX_PORT, 2'b00};
  localparam logic [7:0] A_A = {`TMR_IDX_CTRL_A, 2'b00};
  logic        ref_clk, rst_b, a_wave, d_dir, fcmd, ccmd, gie, ack, fpin, cmp;
  apb_req_t    req;
  apb_rsp_t    rsp;
  cnt_evt_t    ev;
  logic        wav, conn, inv, oe_b, six, imm, bot, fma, trip, irq;
  logic [5:0]  pins;
  logic [31:0] rdata;
  logic        rerr;
  int          num_errors, comparisons;

  pwm_fault_ctrl #(.FILT_LEN(4)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(1'b1), .apb_req(req), .apb_rsp(rsp),
    .cnt_evt(ev), .chan_a_wave(a_wave), .chan_b_wave(1'b0), .chan_d_dir(d_dir),
    .fault_input_pin(fpin), .comparator_out(cmp), .global_irq_en(gie),
    .fault_irq_ack(ack), .chan_d_waveform(wav), .chan_d_conn(conn),
    .chan_d_inv_conn(inv), .chan_d_oe_b(oe_b), .pin_out(pins), .six_phase_mode(six),
    .upd_immediate(imm), .upd_at_bottom(bot), .fault_mode_active(fma),
    .fault_trip(trip), .fault_irq(irq));

  fault_stage stage (
    .ref_clk(ref_clk), .rst_b(rst_b), .fault_cmd(fcmd), .cmp_cmd(ccmd),
    .fault_input_pin(fpin), .comparator_out(cmp));

  // free-running bus clock
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, s, x);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : cyc

  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    // wait for pready at a rising edge; only the watchdog ends a hang
    do
    begin
      @(posedge ref_clk);
    end
    while (rsp.pready !== 1'b1);
    rdata = rsp.prdata;
    rerr = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk(rdata, {24'h00_0000, x});
  endtask : rd

  // one-cycle counter event
  task automatic pulse(input logic m, input logic z);
    @(posedge ref_clk);
    ev.chan_d_match <= m;
    ev.counter_zero <= z;
    @(posedge ref_clk);
    ev.chan_d_match <= 1'b0;
    ev.counter_zero <= 1'b0;
    cyc(2);
  endtask : pulse

  task automatic test_done;
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : test_done

  // watchdog against a hung handshake
  initial
  begin
    cyc(20000);
    num_errors++;
    test_done();
  end

  // main sequence
  initial
  begin
    rst_b = 1'b0; req = '0; ev = '0; a_wave = 1'b0; d_dir = 1'b1;
    fcmd = 1'b1; ccmd = 1'b1; gie = 1'b1; ack = 1'b0;
    num_errors = 0; comparisons = 0;
    cyc(10);
    rst_b <= 1'b1;
    rd(A_C, 8'h00);
    rd(A_D, 8'h00);
    rd(A_E, 8'h00);
    chk({conn, inv, oe_b, imm, bot, six}, 6'b001100);
    apb(1'b0, 8'h00, 8'h00);
    chk(rerr, 1);
    chk(rdata, 0);
    wr(A_A, 8'hA0);
    rd(A_C, 8'hA0);
    wr(A_C, 8'h50);
    rd(A_A, 8'h50);
    wr(A_A, 8'h00);
    // non-pwm: force with mode written at once, then match toggles
    wr(A_C, 8'h0E); cyc(3);
    chk(wav, 1);
    chk({conn, oe_b, inv}, 3'b100);
    d_dir <= 1'b0;
    cyc(2);
    chk(oe_b, 1);
    d_dir <= 1'b1;
    wr(A_C, 8'h0A); cyc(3);
    chk(wav, 0);
    wr(A_C, 8'h06); cyc(3);
    chk(wav, 1);
    pulse(1'b1, 1'b0);
    chk(wav, 0);
    rd(A_C, 8'h04);
    wr(A_C, 8'h00); cyc(3);
    chk({conn, oe_b}, 2'b01);
    // fast pwm on channel d
    wr(A_C, 8'h05); cyc(3);
    chk(inv, 1);
    chk(imm, 1);
    pulse(1'b0, 1'b1);
    chk(wav, 1);
    pulse(1'b1, 1'b0);
    chk(wav, 0);
    wr(A_C, 8'h0D);
    pulse(1'b1, 1'b0);
    chk(wav, 1);
    pulse(1'b0, 1'b1);
    chk(wav, 0);
    // phase and frequency correct
    wr(A_D, 8'h01);
    wr(A_C, 8'h05);
    pulse(1'b1, 1'b0);
    chk(wav, 0);
    ev.count_down <= 1'b1;
    pulse(1'b1, 1'b0);
    chk(wav, 1);
    wr(A_C, 8'h0D);
    pulse(1'b1, 1'b0);
    chk(wav, 0);
    ev.count_down <= 1'b0;
    wr(A_C, 8'h00);
    // wave mode decode and six-phase overrides
    wr(A_A, 8'h02); cyc(3);
    chk({six, imm, bot}, 3'b001);
    wr(A_D, 8'h02);
    wr(A_E, 8'hFF);
    rd(A_E, 8'h3F);
    wr(A_E, 8'h00);
    wr(A_P, 8'h15); cyc(3);
    chk({six, imm, bot}, 3'b100);
    chk(pins, 6'h15);
    wr(A_E, 8'h03); cyc(3);
    chk(pins, 6'h16);
    a_wave <= 1'b1;
    cyc(3);
    chk(pins, 6'h15);
    a_wave <= 1'b0;
    wr(A_D, 8'h03); cyc(3);
    chk({six, bot}, 2'b11);
    wr(A_A, 8'h00); cyc(3);
    chk(imm, 1);
    // fault: falling edge, interrupt enabled
    wr(A_D, 8'hC0);
    fcmd <= 1'b0; cyc(5);
    chk(trip, 1);
    cyc(1);
    chk(trip, 0);
    cyc(2);
    chk(fma, 1);
    rd(A_D, 8'hC4);
    chk(irq, 1);
    gie <= 1'b0; cyc(3);
    chk(irq, 0);
    wr(A_D, 8'hC4); cyc(3);
    rd(A_D, 8'hC0);
    fcmd <= 1'b1; cyc(8);
    rd(A_D, 8'hC0);
    wr(A_D, 8'hD0);
    fcmd <= 1'b0; cyc(8);
    rd(A_D, 8'hD0);
    fcmd <= 1'b1; cyc(8);
    rd(A_D, 8'hD4);
    ack <= 1'b1; cyc(1);
    ack <= 1'b0; cyc(3);
    rd(A_D, 8'hD0);
    gie <= 1'b1;
    wr(A_D, 8'h40);
    fcmd <= 1'b0; cyc(8);
    rd(A_D, 8'h44);
    chk(irq, 0);
    // noise filter: short glitch ignored, long level accepted
    fcmd <= 1'b1; cyc(8);
    wr(A_D, 8'h64); cyc(4);
    fcmd <= 1'b0; cyc(2);
    fcmd <= 1'b1; cyc(12);
    rd(A_D, 8'h60);
    fcmd <= 1'b0; cyc(12);
    rd(A_D, 8'h64);
    // comparator source
    fcmd <= 1'b1; cyc(8);
    wr(A_D, 8'h44); cyc(3);
    ccmd <= 1'b0; cyc(8);
    rd(A_D, 8'h40);
    ccmd <= 1'b1; cyc(8);
    wr(A_D, 8'h48);
    ccmd <= 1'b0; cyc(8);
    rd(A_D, 8'h4C);
    test_done();
  end
endmodule : testbench

/* File: timer_params.svh */
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
// register indices, byte address is four times the index
`define TMR_IDX_CTRL_C    6'h27
`define TMR_IDX_CTRL_D    6'h26
`define TMR_IDX_CTRL_E    6'h2C
`define TMR_IDX_PORT      6'h2D
`define TMR_IDX_CTRL_A    6'h30
`define TMR_ADDR_W        8
// control c fields
`define TMR_C_COMA        7:6
`define TMR_C_COMB        5:4
`define TMR_C_COMD        3:2
`define TMR_C_FORCE       1
`define TMR_C_PWMD        0
// control a fields
`define TMR_A_COMA        7:6
`define TMR_A_COMB        5:4
`define TMR_A_PWMA        1
`define TMR_A_PWMB        0
// control d fields
`define TMR_D_FPIE        7
`define TMR_D_FPEN        6
`define TMR_D_FPNC        5
`define TMR_D_FPES        4
`define TMR_D_FPAC        3
`define TMR_D_FLAG        2
`define TMR_D_WAVE        1:0
// control e and port data fields
`define TMR_E_OE          5:0
// output mode codes
`define TMR_COM_PORT      2'h0
`define TMR_COM_TOGGLE    2'h1
`define TMR_COM_CLEAR     2'h2
`define TMR_COM_SET       2'h3
// reset values and filter length
`define TMR_RST_BYTE      8'h00
`define TMR_RST_WORD      32'h0000_0000
`define TMR_FILT_SAMPLES  4
`endif

/* File: timer_pkg.sv */
package timer_pkg;
  // apb request as seen by the slave
  typedef struct packed {
    logic                     psel;
    logic                     penable;
    logic                     pwrite;
    logic [7:0]               paddr;
    logic [31:0]              pwdata;
  } apb_req_t;

  // apb answer from the slave
  typedef struct packed {
    logic                     pready;
    logic                     pslverr;
    logic [31:0]              prdata;
  } apb_rsp_t;

  // waveform generation mode when pwm is enabled
  typedef enum logic [1:0] {
    WAVE_FAST     = 2'b00,
    WAVE_PFC      = 2'b01,
    WAVE_SIX_SS   = 2'b10,
    WAVE_SIX_DS   = 2'b11
  } wave_mode_t;

  // timer-side events from the counter core
  typedef struct packed {
    logic                     chan_d_match;
    logic                     counter_zero;
    logic                     count_down;
  } cnt_evt_t;
endpackage : timer_pkg
